//--- rtl/ubd_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// fractional baud tick generator
// ****************************************************************
module ubd_baud_gen #(
	parameter int INT_W = 16,
	parameter int FRAC_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [INT_W-1:0] div_int,
	input wire logic [FRAC_W-1:0] div_frac,
	output logic tick_q
);
	// the counter and accumulator need at least one bit each
	if (INT_W < 1 || FRAC_W < 1) begin : g_bad_width
		$error("divisor widths must be at least one bit");
	end

	logic [INT_W:0] cnt_q;
	logic [FRAC_W-1:0] acc_q;
	logic extra_q;
	logic [FRAC_W:0] acc_sum;
	logic [INT_W:0] period;

	// period is the whole part, stretched by one cycle on fraction carry
	assign acc_sum = {1'b0, acc_q} + {1'b0, div_frac};
	assign period = {1'b0, div_int} + {{INT_W{1'b0}}, extra_q};

	// cycle counter; a zero whole part means divide by one, fraction ignored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_q <= {{INT_W{1'b0}}, 1'b1};
			acc_q <= '0;
			extra_q <= 1'b0;
			tick_q <= 1'b0;
		end else if (div_int == '0) begin
			cnt_q <= {{INT_W{1'b0}}, 1'b1};
			acc_q <= '0;
			extra_q <= 1'b0;
			tick_q <= 1'b1;
		end else if (cnt_q >= period) begin
			// fraction counts sixty-fourths, carry adds one cycle next period
			cnt_q <= {{INT_W{1'b0}}, 1'b1};
			acc_q <= acc_sum[FRAC_W-1:0];
			extra_q <= acc_sum[FRAC_W];
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + {{INT_W{1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end

endmodule : ubd_baud_gen

`default_nettype wire

//--- rtl/ubd_line_ctrl.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - whole divisor is 16 bits, upper half reads zero, clears on reset.
// - whole divisor zero divides by one and ignores the fraction.
// - new divisor applies only after the current character finishes.
// - divisor commits to the baud generator only on line control write.
// - fraction divisor is 6 bits, upper bits read zero, clears on reset.
// - stick, parity enable and even select set: parity bit is 0.
// - stick and parity enable set, even clear: parity is 1.
// - word length field 0..3 selects 5..8 data bits, reset 5.
// - fifo enable clear selects character mode with one-byte holding.
// - fifo enable set selects full fifo mode.
// - parity enable clear omits parity; set generates and checks it.
// - even select picks even or odd parity, no effect when disabled.
module ubd_line_ctrl
	import ubd_pkg::*;
#(
	parameter int DIV_INT_W = UBD_DIV_INT_W,
	parameter int DIV_FRAC_W = UBD_DIV_FRAC_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic char_busy,
	input wire logic [7:0] tx_char,
	input wire logic [7:0] rx_char,
	input wire logic rx_parity_bit,
	output logic baud_tick,
	output logic [3:0] data_bits,
	output logic parity_enable,
	output logic tx_parity_bit,
	output logic rx_parity_err,
	output logic fifo_mode,
	output logic two_stop,
	output logic send_break
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (DIV_INT_W < 1 || DIV_INT_W > 16) begin : g_bad_int
		$error("whole divisor width must be 1 to 16");
	end
	if (DIV_FRAC_W < 1 || DIV_FRAC_W > 6) begin : g_bad_frac
		$error("fraction divisor width must be 1 to 6");
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	ubd_bus_state_t bus_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wr_go;
	logic [DIV_INT_W-1:0] div_int_q;
	logic [DIV_FRAC_W-1:0] div_frac_q;
	logic [UBD_LCR_W-1:0] lcr_q;
	logic [UBD_LCR_W-1:0] lcr_d;
	logic [DIV_INT_W-1:0] act_int_q;
	logic [DIV_FRAC_W-1:0] act_frac_q;
	logic pending_q;
	logic commit;
	logic [15:0] wr_int;
	logic wait_q;

	// the write takes effect at the edge that ends the answer cycle
	assign wr_go = avs_write && bus_q == UBD_BUS_ANSWER;
	assign avs_waitrequest = wait_q; // own flop, mirrors the answer state
	assign avs_readdata = rdata_q;

	// one wait cycle per access keeps read data coming from a flop
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_q <= UBD_BUS_IDLE;
			wait_q <= 1'b1;
		end else begin
			case (bus_q)
				UBD_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_q <= UBD_BUS_ANSWER;
						wait_q <= 1'b0;
					end
				end
				UBD_BUS_ANSWER: begin
					bus_q <= UBD_BUS_IDLE;
					wait_q <= 1'b1;
				end
				default: begin
					bus_q <= UBD_BUS_IDLE;
					wait_q <= 1'b1;
				end
			endcase
		end
	end

	// read mux; reserved bits and unmapped words read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address)
			UBD_OFS_DIV_INT: rdata_d[DIV_INT_W-1:0] = div_int_q;
			UBD_OFS_DIV_FRAC: rdata_d[DIV_FRAC_W-1:0] = div_frac_q;
			UBD_OFS_LINE_CTRL: rdata_d[UBD_LCR_W-1:0] = lcr_q;
			UBD_OFS_STATUS: begin
				rdata_d[UBD_POS_ST_PENDING] = pending_q;
				rdata_d[UBD_POS_ST_BUSY] = char_busy;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && bus_q == UBD_BUS_IDLE) begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// programmed registers
	// ****************************************************************
	// byte lanes merged onto the old whole divisor
	always_comb begin
		wr_int = 16'h0000;
		wr_int[DIV_INT_W-1:0] = div_int_q;
		if (avs_byteenable[0]) begin
			wr_int[7:0] = avs_writedata[7:0];
		end
		if (avs_byteenable[1]) begin
			wr_int[15:8] = avs_writedata[15:8];
		end
		lcr_d = avs_byteenable[0] ? avs_writedata[UBD_LCR_W-1:0] : lcr_q;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_int_q <= UBD_RST_DIV_INT[DIV_INT_W-1:0];
		end else if (wr_go && avs_address == UBD_OFS_DIV_INT) begin
			div_int_q <= wr_int[DIV_INT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_frac_q <= UBD_RST_DIV_FRAC[DIV_FRAC_W-1:0];
		end else if (wr_go && avs_address == UBD_OFS_DIV_FRAC && avs_byteenable[0]) begin
			div_frac_q <= avs_writedata[DIV_FRAC_W-1:0];
		end
	end

	// line fields act at once; only the divisor waits for a boundary
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lcr_q <= UBD_RST_LINE_CTRL;
		end else if (wr_go && avs_address == UBD_OFS_LINE_CTRL) begin
			lcr_q <= lcr_d;
		end
	end

	// ****************************************************************
	// divisor commit
	// ****************************************************************
	// software must write line control after a divisor change, else no effect
	assign commit = pending_q && !char_busy;

	// a new line control write wins over the clear of the same cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pending_q <= 1'b0;
		end else if (wr_go && avs_address == UBD_OFS_LINE_CTRL) begin
			pending_q <= 1'b1;
		end else if (commit) begin
			pending_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			act_int_q <= UBD_RST_DIV_INT[DIV_INT_W-1:0];
			act_frac_q <= UBD_RST_DIV_FRAC[DIV_FRAC_W-1:0];
		end else if (commit) begin
			act_int_q <= div_int_q;
			act_frac_q <= div_frac_q;
		end
	end

	ubd_baud_gen #(
		.INT_W(DIV_INT_W),
		.FRAC_W(DIV_FRAC_W)
	) u_gen (
		.clk(clk),
		.reset_n(reset_n),
		.div_int(act_int_q),
		.div_frac(act_frac_q),
		.tick_q(baud_tick)
	);

	// ****************************************************************
	// framing and parity
	// ****************************************************************
	logic par_en;
	logic even_sel;
	logic stick_sel;
	logic [1:0] word_len;
	logic [7:0] mask;
	logic tx_par;
	logic rx_par;

	assign par_en = lcr_q[UBD_POS_PARITY_ENABLE];
	assign even_sel = lcr_q[UBD_POS_EVEN_PARITY];
	assign stick_sel = lcr_q[UBD_POS_STICK_PARITY];
	assign word_len = lcr_q[UBD_POS_WORD_LEN_HI:UBD_POS_WORD_LEN_LO];
	assign mask = 8'hFF >> (UBD_WORD_LEN_8 - word_len);

	// stick level is the inverse of even select; else even or odd sum
	always_comb begin
		if (stick_sel) begin
			tx_par = !even_sel;
			rx_par = !even_sel;
		end else begin
			tx_par = even_sel ? ^(tx_char & mask) : ~^(tx_char & mask);
			rx_par = even_sel ? ^(rx_char & mask) : ~^(rx_char & mask);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_parity_bit <= 1'b0;
			rx_parity_err <= 1'b0;
		end else begin
			tx_parity_bit <= par_en && tx_par;
			rx_parity_err <= par_en && (rx_parity_bit != rx_par);
		end
	end

	// remaining line fields registered onto the outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			data_bits <= UBD_MIN_DATA_BITS;
			parity_enable <= 1'b0;
			fifo_mode <= 1'b0;
			two_stop <= 1'b0;
			send_break <= 1'b0;
		end else begin
			data_bits <= UBD_MIN_DATA_BITS + {2'b00, word_len};
			parity_enable <= par_en;
			fifo_mode <= lcr_q[UBD_POS_FIFO_ENABLE];
			two_stop <= lcr_q[UBD_POS_TWO_STOP];
			send_break <= lcr_q[UBD_POS_SEND_BREAK];
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_int_read;
		avs_read && !avs_waitrequest && avs_address == UBD_OFS_DIV_INT;
	endsequence

	chk_int_upper_zero: assert property (s_int_read |-> avs_readdata[31:16] == 16'h0000)
		else $error("whole divisor upper half not zero");
	chk_frac_upper_zero: assert property (avs_read && !avs_waitrequest
		&& avs_address == UBD_OFS_DIV_FRAC |-> avs_readdata[31:6] == 26'h0)
		else $error("fraction upper bits not zero");
	// the first cycle must lie outside reset, where the tick is held low
	chk_zero_div_tick: assert property ((reset_n && act_int_q == '0)[*2] |-> baud_tick)
		else $error("zero divisor did not tick every cycle");
	chk_commit_needs_lcr: assert property ($changed(act_int_q) || $changed(act_frac_q)
		|-> $past(pending_q))
		else $error("divisor changed without line control write");
	chk_commit_boundary: assert property ($changed(act_int_q) |-> !$past(char_busy))
		else $error("divisor changed inside a character");
	chk_divisor_hold: assert property (char_busy
		|=> $stable(act_int_q) && $stable(act_frac_q))
		else $error("divisor moved while a character was busy");
	chk_lcr_sets_pending: assert property (wr_go && avs_address == UBD_OFS_LINE_CTRL
		|=> pending_q)
		else $error("line control write did not arm the divisor commit");
	chk_commit_follows: assert property (pending_q && !char_busy |=> !pending_q
		|| $past(wr_go))
		else $error("pending divisor not taken at a boundary");
	chk_stick_zero: assert property (stick_sel && par_en && even_sel |=> !tx_parity_bit)
		else $error("stick parity not zero");
	chk_stick_one: assert property (stick_sel && par_en && !even_sel && rx_parity_bit
		|=> tx_parity_bit && !rx_parity_err)
		else $error("stick parity not one");
	chk_word_length: assert property (##1 data_bits == 4'h5 + {2'b00, $past(word_len)})
		else $error("data bits do not follow word length");
	chk_fifo_mode: assert property (##1 fifo_mode == $past(lcr_q[UBD_POS_FIFO_ENABLE]))
		else $error("fifo mode not following enable");
	chk_no_parity: assert property (!par_en |=> !tx_parity_bit && !rx_parity_err)
		else $error("parity active while disabled");

endmodule : ubd_line_ctrl

`default_nettype wire

//--- rtl/ubd_pkg.sv
package ubd_pkg;

	// ****************************************************************
	// register offsets (byte addresses, one aligned word each)
	// ****************************************************************
	localparam logic [5:0] UBD_OFS_DIV_INT = 6'h24;
	localparam logic [5:0] UBD_OFS_DIV_FRAC = 6'h28;
	localparam logic [5:0] UBD_OFS_LINE_CTRL = 6'h2C;
	localparam logic [5:0] UBD_OFS_STATUS = 6'h30;

	// ****************************************************************
	// field widths and positions
	// ****************************************************************
	localparam int UBD_DIV_INT_W = 16;
	localparam int UBD_DIV_FRAC_W = 6;
	localparam int UBD_LCR_W = 8;
	localparam int UBD_POS_SEND_BREAK = 0;
	localparam int UBD_POS_PARITY_ENABLE = 1;
	localparam int UBD_POS_EVEN_PARITY = 2;
	localparam int UBD_POS_TWO_STOP = 3;
	localparam int UBD_POS_FIFO_ENABLE = 4;
	localparam int UBD_POS_WORD_LEN_LO = 5;
	localparam int UBD_POS_WORD_LEN_HI = 6;
	localparam int UBD_POS_STICK_PARITY = 7;
	localparam int UBD_POS_ST_PENDING = 0;
	localparam int UBD_POS_ST_BUSY = 1;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0] UBD_RST_DIV_INT = 16'h0000;
	localparam logic [5:0] UBD_RST_DIV_FRAC = 6'h00;
	localparam logic [7:0] UBD_RST_LINE_CTRL = 8'h00;

	// ****************************************************************
	// framing constants
	// ****************************************************************
	localparam logic [3:0] UBD_MIN_DATA_BITS = 4'h5;
	localparam logic [1:0] UBD_WORD_LEN_8 = 2'h3;

	// avalon slave handshake
	typedef enum logic [0:0] {UBD_BUS_IDLE, UBD_BUS_ANSWER} ubd_bus_state_t;

endpackage : ubd_pkg

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module tb
	import ubd_pkg::*;
;
	typedef struct packed {logic [7:0] lcr; logic [7:0] tx; logic [3:0] db; logic pe; logic par;
		logic fifo;} ubd_row_t;
	logic clk, reset_n, avs_read, avs_write, avs_waitrequest, char_busy, rx_parity_bit;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0] tx_char, rx_char;
	logic [3:0] data_bits;
	logic baud_tick, parity_enable, tx_parity_bit, rx_parity_err, fifo_mode, start, corrupt;
	logic two_stop, send_break;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int c;
	// masked data decides parity, so 8'h60 in six bits is odd count
	ubd_row_t rows [8] = '{
		'{8'h09, 8'hFF, 4'h5, 1'b0, 1'b0, 1'b0}, '{8'h22, 8'h01, 4'h6, 1'b1, 1'b0, 1'b0},
		'{8'h26, 8'h60, 4'h6, 1'b1, 1'b1, 1'b0}, '{8'h46, 8'h07, 4'h7, 1'b1, 1'b1, 1'b0},
		'{8'h70, 8'hFF, 4'h8, 1'b0, 1'b0, 1'b1}, '{8'h86, 8'hFF, 4'h5, 1'b1, 1'b0, 1'b0},
		'{8'h82, 8'h00, 4'h5, 1'b1, 1'b1, 1'b0}, '{8'h94, 8'h01, 4'h5, 1'b0, 1'b0, 1'b1}};

	// ****************************************************************
	// clock, design and far end
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	ubd_line_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.char_busy(char_busy), .tx_char(tx_char), .rx_char(rx_char),
		.rx_parity_bit(rx_parity_bit), .baud_tick(baud_tick), .data_bits(data_bits),
		.parity_enable(parity_enable), .tx_parity_bit(tx_parity_bit),
		.rx_parity_err(rx_parity_err), .fifo_mode(fifo_mode), .two_stop(two_stop),
		.send_break(send_break));

	ubd_remote_model far (.clk(clk), .reset_n(reset_n), .start(start), .corrupt(corrupt),
		.tx_char(tx_char), .tx_parity_bit(tx_parity_bit), .char_busy(char_busy),
		.rx_char(rx_char), .rx_parity_bit(rx_parity_bit));

	// ****************************************************************
	// tasks
	// ****************************************************************
	// request held until waitrequest is seen low at a rising edge;
	// a fresh edge first, so a release is never overwritten in its own step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// cycles covered by n tick intervals
	task automatic span(input int n, output int cyc);
		cyc = 0;
		do @(negedge clk); while (baud_tick !== 1'b1);
		repeat (n) begin
			do begin @(negedge clk); cyc++; end while (baud_tick !== 1'b1);
		end
	endtask : span

	// divisor writes always followed by the committing line write
	task automatic setdiv(input logic [31:0] w, input logic [31:0] f);
		bus(1'b1, UBD_OFS_DIV_INT, w, q);
		bus(1'b1, UBD_OFS_DIV_FRAC, f, q);
		bus(1'b1, UBD_OFS_LINE_CTRL, 32'h00000000, q);
	endtask : setdiv

	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		{avs_read, avs_write, start, corrupt} = 4'h0;
		avs_address = 6'h00;
		avs_writedata = 32'h00000000;
		tx_char = 8'h00;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, UBD_OFS_DIV_INT, 32'h0, q);
		`CHK(q, 32'h00000000)
		bus(1'b0, UBD_OFS_DIV_FRAC, 32'h0, q);
		`CHK(q, 32'h00000000)
		bus(1'b0, UBD_OFS_LINE_CTRL, 32'h0, q);
		`CHK(q, 32'h00000000)
		`CHK(data_bits, 4'h5)
		span(4, c);
		`CHK(c, 4)
		// line control rows: fields act at once, parity on the looped char
		foreach (rows[i]) begin
			@(posedge clk);
			tx_char <= rows[i].tx;
			corrupt <= 1'b0;
			bus(1'b1, UBD_OFS_LINE_CTRL, {24'h0, rows[i].lcr}, q);
			// third edge: the echoed parity bit has caught up with the new fields
			repeat (3) @(negedge clk);
			`CHK(data_bits, rows[i].db)
			`CHK(parity_enable, rows[i].pe)
			`CHK(tx_parity_bit, rows[i].par)
			`CHK(fifo_mode, rows[i].fifo)
			`CHK(two_stop, rows[i].lcr[UBD_POS_TWO_STOP]) // stored line field
			`CHK(send_break, rows[i].lcr[UBD_POS_SEND_BREAK]) // stored line field
			`CHK(rx_parity_err, 1'b0)
			@(posedge clk);
			corrupt <= 1'b1;
			repeat (2) @(negedge clk);
			`CHK(rx_parity_err, rows[i].pe)
			bus(1'b0, UBD_OFS_LINE_CTRL, 32'h0, q);
			`CHK(q, {24'h0, rows[i].lcr})
		end
		// reserved bits, unmapped place, and a divisor left uncommitted
		bus(1'b1, UBD_OFS_DIV_INT, 32'hFFFFFFFF, q);
		bus(1'b0, UBD_OFS_DIV_INT, 32'h0, q);
		`CHK(q, 32'h0000FFFF)
		bus(1'b1, UBD_OFS_DIV_FRAC, 32'hFFFFFFFF, q);
		bus(1'b0, UBD_OFS_DIV_FRAC, 32'h0, q);
		`CHK(q, 32'h0000003F)
		bus(1'b1, 6'h3C, 32'hFFFFFFFF, q);
		bus(1'b0, 6'h3C, 32'h0, q);
		`CHK(q, 32'h00000000)
		span(4, c);
		`CHK(c, 4)
		// commit during a frame must wait for the frame to end
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		setdiv(32'h3, 32'h0);
		span(4, c);
		`CHK(c, 4)
		bus(1'b0, UBD_OFS_STATUS, 32'h0, q);
		`CHK(q, 32'h00000003)
		do @(negedge clk); while (char_busy !== 1'b0);
		span(1, c);
		span(4, c);
		`CHK(c, 12)
		bus(1'b0, UBD_OFS_STATUS, 32'h0, q);
		`CHK(q, 32'h00000000)
		setdiv(32'h0, 32'h20);
		span(1, c);
		span(4, c);
		`CHK(c, 4)
		setdiv(32'h2, 32'h20);
		span(1, c);
		span(4, c);
		`CHK(c, 10)
		end_sim();
	end
endmodule : tb
`default_nettype wire

//--- verif/ubd_remote_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// remote serial end: frames the line and loops characters back
// ****************************************************************
module ubd_remote_model #(
	parameter int FRAME_CYCLES = 60
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic corrupt,
	input wire logic [7:0] tx_char,
	input wire logic tx_parity_bit,
	output logic char_busy,
	output logic [7:0] rx_char,
	output logic rx_parity_bit
);
	int cnt_q;

	// busy spans one whole frame after a start request
	always_ff @(posedge clk) begin
		if (!reset_n) cnt_q <= 0;
		else if (start) cnt_q <= FRAME_CYCLES;
		else if (cnt_q != 0) cnt_q <= cnt_q - 1;
	end
	assign char_busy = (cnt_q != 0);

	// echo one cycle late, so it lines up with the registered parity
	always_ff @(posedge clk) begin
		rx_char <= tx_char;
	end

	// a flipped parity bit is the only fault a scenario asks for
	assign rx_parity_bit = tx_parity_bit ^ corrupt;
endmodule : ubd_remote_model
`default_nettype wire
